/* uawk_pkg.sv */
// Package of constants and carrier types for the auto-wake-up block
package uawk_pkg;
   // Register byte offsets
   localparam logic [3:0] BAUD_CTRL_OFS = 4'h0;
   localparam logic [3:0] RX_BUF_OFS = 4'h4;
   localparam logic [3:0] INT_STAT_OFS = 4'h8;
   localparam logic [3:0] INT_MASK_OFS = 4'hc;
   // Baud control field positions
   localparam int WAKE_EN_POS = 1;
   localparam int ASYNC_POS = 0;
   localparam int RX_IDLE_POS = 2;
   localparam int SLEEP_POS = 3;
   // Interrupt status field positions
   localparam int WAKE_EV_POS = 0;
   localparam int WAKE_END_POS = 1;
   // Reset values
   localparam logic [7:0] BAUD_CTRL_RST = 8'h01;
   localparam logic [1:0] INT_MASK_RST = 2'h0;
   localparam logic [7:0] RX_BUF_RST = 8'h00;

   typedef enum logic [1:0]
   {
      ST_NORMAL = 2'b00,
      ST_ARMED = 2'b01,
      ST_WOKEN = 2'b10
   } uawk_state_t;

   typedef struct packed
   {
      uawk_state_t state;
      logic async_mode;
      logic wake_en;
      logic sleep_req;
      logic rx_int_flag;
      logic [1:0] int_stat;
      logic [1:0] int_mask;
      logic rxd_prev;
      logic [7:0] rx_buf;
      logic ack;
      logic [31:0] dat;
   } uawk_regs_t;
endpackage

/* uawk_wake.sv */
// Auto-wake-up logic of the asynchronous receiver with Wishbone registers
//
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module uawk_wake
#(
   parameter int ADDR_W = 4
)
(
   input wire logic clk_i, // 125 MHz clock
   input wire logic rst_i, // Sync reset, active high
   input wire logic [ADDR_W-1:0] adr_i, // Wishbone byte address
   input wire logic [31:0] dat_i, // Write data
   input wire logic [3:0] sel_i, // Byte selects
   input wire logic we_i, // Write enable
   input wire logic cyc_i, // Cycle
   input wire logic stb_i, // Strobe
   output logic [31:0] dat_o, // Read data
   output logic ack_o, // Acknowledge
   input wire logic receive_line_i, // Serial receive line
   input wire logic rx_busy_i, // Normal receiver mid-byte
   input wire logic [7:0] rx_data_i, // Byte from normal receiver
   input wire logic rx_data_vld_i, // Byte complete pulse
   output logic rx_enable_o, // Normal reception allowed
   output logic receive_int_flag_o, // Receive interrupt flag
   output logic wake_o, // Wake request to clock control
   output logic irq_o // Level interrupt
);
   initial
   begin
      if (ADDR_W < 4)
      begin
         $error("ADDR_W too small");
      end
   end

   uawk_pkg::uawk_regs_t r_ff;
   uawk_pkg::uawk_regs_t nxt_r;
   logic req;
   logic wr;
   logic rd;
   logic fall;
   logic rise;
   logic [3:0] ofs;

   // Bus decode
   assign req = cyc_i && stb_i && !r_ff.ack;
   assign wr = req && we_i;
   assign rd = req && !we_i;
   assign ofs = adr_i[3:0];
   // Line edges against previous sample
   assign fall = r_ff.rxd_prev && !receive_line_i;
   assign rise = !r_ff.rxd_prev && receive_line_i;

   // Next state
   always_comb
   begin
      nxt_r = r_ff;
      nxt_r.rxd_prev = receive_line_i;
      nxt_r.ack = req;
      nxt_r.dat = 32'h0;
      // Reading the receive buffer clears the flag; a set below wins
      if (rd && ofs == uawk_pkg::RX_BUF_OFS)
      begin
         nxt_r.rx_int_flag = 1'b0;
         nxt_r.dat = {24'h0, r_ff.rx_buf};
      end
      // Normal byte reception lands in the buffer only in the normal state, not when armed or woken
      if (rx_data_vld_i && r_ff.state == uawk_pkg::ST_NORMAL)
      begin
         nxt_r.rx_buf = rx_data_i;
         nxt_r.rx_int_flag = 1'b1;
      end
      if (rd && ofs == uawk_pkg::BAUD_CTRL_OFS)
      begin
         nxt_r.dat = 32'h0;
         nxt_r.dat[uawk_pkg::ASYNC_POS] = r_ff.async_mode;
         nxt_r.dat[uawk_pkg::WAKE_EN_POS] = r_ff.wake_en;
         nxt_r.dat[uawk_pkg::RX_IDLE_POS] = !rx_busy_i;
         nxt_r.dat[uawk_pkg::SLEEP_POS] = r_ff.sleep_req;
      end
      if (rd && ofs == uawk_pkg::INT_STAT_OFS)
      begin
         nxt_r.dat = {30'h0, r_ff.int_stat};
      end
      if (rd && ofs == uawk_pkg::INT_MASK_OFS)
      begin
         nxt_r.dat = {30'h0, r_ff.int_mask};
      end
      // Register writes
      if (wr && sel_i[0] && ofs == uawk_pkg::BAUD_CTRL_OFS)
      begin
         nxt_r.async_mode = dat_i[uawk_pkg::ASYNC_POS];
         nxt_r.wake_en = dat_i[uawk_pkg::WAKE_EN_POS];
         nxt_r.sleep_req = dat_i[uawk_pkg::SLEEP_POS];
      end
      if (wr && sel_i[0] && ofs == uawk_pkg::INT_STAT_OFS)
      begin
         nxt_r.int_stat = r_ff.int_stat & ~dat_i[1:0];
      end
      if (wr && sel_i[0] && ofs == uawk_pkg::INT_MASK_OFS)
      begin
         nxt_r.int_mask = dat_i[1:0];
      end
      // Wake sequencer
      case (r_ff.state)
         uawk_pkg::ST_NORMAL:
         begin
            if (r_ff.wake_en && r_ff.async_mode)
            begin
               nxt_r.state = uawk_pkg::ST_ARMED;
            end
         end
         uawk_pkg::ST_ARMED:
         begin
            if (!nxt_r.wake_en || !nxt_r.async_mode)
            begin
               nxt_r.state = uawk_pkg::ST_NORMAL;
            end
            else if (fall)
            begin
               nxt_r.rx_int_flag = 1'b1;
               nxt_r.int_stat[uawk_pkg::WAKE_EV_POS] = 1'b1;
               nxt_r.state = uawk_pkg::ST_WOKEN;
            end
         end
         uawk_pkg::ST_WOKEN:
         begin
            // A rising edge after the fall ends the wake-up; clearing wake_en or async_mode also returns to normal
            if (rise)
            begin
               nxt_r.wake_en = 1'b0;
               nxt_r.int_stat[uawk_pkg::WAKE_END_POS] = 1'b1;
               nxt_r.state = uawk_pkg::ST_NORMAL;
            end
            else if (!nxt_r.wake_en || !nxt_r.async_mode)
            begin
               nxt_r.state = uawk_pkg::ST_NORMAL;
            end
         end
         default:
         begin
            nxt_r.state = uawk_pkg::ST_NORMAL;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         r_ff.state <= uawk_pkg::ST_NORMAL;
         r_ff.async_mode <= uawk_pkg::BAUD_CTRL_RST[uawk_pkg::ASYNC_POS];
         r_ff.wake_en <= uawk_pkg::BAUD_CTRL_RST[uawk_pkg::WAKE_EN_POS];
         r_ff.sleep_req <= uawk_pkg::BAUD_CTRL_RST[uawk_pkg::SLEEP_POS];
         r_ff.rx_int_flag <= 1'b0;
         r_ff.int_stat <= 2'h0;
         r_ff.int_mask <= uawk_pkg::INT_MASK_RST;
         r_ff.rxd_prev <= 1'b1;
         r_ff.rx_buf <= uawk_pkg::RX_BUF_RST;
         r_ff.ack <= 1'b0;
         r_ff.dat <= 32'h0;
      end
      else
      begin
         r_ff <= nxt_r;
      end
   end

   // Outputs
   assign dat_o = r_ff.dat;
   assign ack_o = r_ff.ack;
   // Reception held off while armed or woken, or in sleep
   assign rx_enable_o = (r_ff.state == uawk_pkg::ST_NORMAL) && !r_ff.sleep_req;
   assign receive_int_flag_o = r_ff.rx_int_flag;
   // Combinational wake in sleep: a falling line while armed raises wake at once
   assign wake_o = r_ff.sleep_req && (r_ff.state == uawk_pkg::ST_ARMED) && !receive_line_i;
   assign irq_o = |(r_ff.int_stat & r_ff.int_mask);
endmodule
`default_nettype wire

/* uawk_asserts.sv */
// Port checker for the auto-wake-up block
`timescale 1ns/1ns
`default_nettype none
module uawk_asserts
(
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Reset
   input wire logic cyc_i, // Cycle
   input wire logic stb_i, // Strobe
   input wire logic we_i, // Write
   input wire logic ack_o, // Ack
   input wire logic receive_line_i, // Line
   input wire logic rx_data_vld_i, // Byte pulse
   input wire logic rx_enable_o, // Rx on
   input wire logic receive_int_flag_o, // Flag
   input wire logic wake_o, // Wake
   input wire logic irq_o // Irq
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   chk_ack_take: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not acked");
   chk_ack_cause: assert property (ack_o |-> $past(cyc_i) && $past(stb_i))
      else $error("ack without request");
   chk_wake_line: assert property (wake_o |-> !receive_line_i && !rx_enable_o)
      else $error("wake without low line");
   chk_flag_cause: assert property ($rose(receive_int_flag_o) |->
      $past(rx_data_vld_i) || ($past(receive_line_i, 2) && !$past(receive_line_i)))
      else $error("flag without cause");
   chk_fall_idle: assert property ($fell(receive_line_i) && rx_enable_o && !rx_data_vld_i
      |=> !$rose(receive_int_flag_o)) else $error("flag on unarmed fall");
   chk_rxen_back: assert property ($rose(rx_enable_o) |-> $past(we_i) ||
      ($past(receive_line_i) && !$past(receive_line_i, 2))) else $error("bad resume");
   chk_rst_quiet: assert property ($fell(rst_i) |->
      rx_enable_o && !irq_o && !receive_int_flag_o && !wake_o) else $error("bad reset");
   // Main scenarios
   cover property ($rose(receive_int_flag_o));
   cover property (wake_o);
   cover property ($rose(rx_enable_o));
endmodule
bind uawk_wake uawk_asserts u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .ack_o,
   .receive_line_i, .rx_data_vld_i, .rx_enable_o, .receive_int_flag_o, .wake_o, .irq_o);
`default_nettype wire

/* uawk_tx_model.sv */
// Remote transmitter sending an all-zero wake character
`timescale 1ns/1ns
`default_nettype none
module uawk_tx_model
(
   input wire logic clk_i, // Clock
   input wire logic go_i, // Start a break
   input wire logic [7:0] len_i, // Low cycles
   output logic line_o // Serial line
);
   int cnt = 0;
   // Zero character, then an idle-high gap
   always @(posedge clk_i)
   begin
      if (go_i && cnt == 0)
         cnt <= len_i + 8;
      else if (cnt > 0)
         cnt <= cnt - 1;
   end
   assign line_o = !(cnt > 8);
endmodule
`default_nettype wire

/* tb_uawk_wake.sv */
// Self-checking bench for the auto-wake-up block
`timescale 1ns/1ns
`default_nettype none
module tb_uawk_wake;
   logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, vld = 0, go = 0, hold_lo = 0;
   logic [3:0] adr = 4'h0;
   logic [7:0] rxd = 8'h0, len = 8'h6;
   logic [31:0] wdat = 32'h0, rd, dat_o, seed = 32'h5a;
   logic ack, rxen, flag, wake, irq, tx_line;
   logic [7:0] q[$];
   int error_cnt = 0, samples_checked = 0;
   wire logic line = tx_line & !hold_lo;
   always #4 clk_i = !clk_i;
   uawk_wake u_dut (.clk_i, .rst_i, .adr_i(adr), .dat_i(wdat), .sel_i(4'hf), .we_i(we),
      .cyc_i(cyc), .stb_i(stb), .dat_o, .ack_o(ack), .receive_line_i(line), .rx_busy_i(1'b0),
      .rx_data_i(rxd), .rx_data_vld_i(vld), .rx_enable_o(rxen), .receive_int_flag_o(flag),
      .wake_o(wake), .irq_o(irq));
   uawk_tx_model u_tx (.clk_i, .go_i(go), .len_i(len), .line_o(tx_line));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
         error_cnt++;
      end
   endtask
   // Classic single bus cycle
   task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      {adr, we, wdat, cyc, stb} <= {a, w, d, 2'b11};
      n = 0;
      do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
      if (n == 50) error_cnt++;
      rd = dat_o;
      {cyc, stb} <= 2'b00;
   endtask
   // Pulse one byte from the normal receiver
   task automatic byte_in();
      @(posedge clk_i);
      rxd <= 8'(rnd());
      vld <= 1'b1;
      @(posedge clk_i);
      vld <= 1'b0;
   endtask
   task automatic results();
      if (error_cnt == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(4'h0, 0, 0); chk(rd, 32'(uawk_pkg::BAUD_CTRL_RST) | 32'h4);
      wb(4'h8, 0, 0); chk(rd, 0); wb(4'hc, 0, 0); chk(rd, 0); wb(4'h1, 0, 0); chk(rd, 0);
      byte_in(); q.push_back(rxd); wb(4'h4, 0, 0); chk(rd, 32'(q[$]));
      wb(4'hc, 1, 1); hold_lo <= 1'b1; wb(4'h0, 1, 3);
      repeat (2) @(posedge clk_i);
      hold_lo <= 1'b0;
      byte_in(); wb(4'h0, 0, 0); chk(rd, 7); chk(32'(flag), 0);
      wb(4'h4, 0, 0); chk(rd, 32'(q[$]));
      for (int i = 0; i < 3; i++)
      begin
         wb(4'h0, 1, 3); len <= 8'(6 + rnd() % 10); go <= 1'b1;
         @(posedge clk_i); go <= 1'b0;
         repeat (4) @(posedge clk_i); chk({flag, irq, rxen}, 6);
         repeat (16) @(posedge clk_i); wb(4'h0, 0, 0); chk(rd, 5); chk(32'(rxen), 1);
         wb(4'h8, 0, 0); chk(rd, 3); wb(4'h4, 0, 0); @(posedge clk_i); chk(32'(flag), 0);
         wb(4'h8, 1, 3); wb(4'h8, 0, 0); chk(rd, 0); chk(32'(irq), 0);
      end
      wb(4'h0, 1, 2); go <= 1'b1; @(posedge clk_i); go <= 1'b0;
      repeat (24) @(posedge clk_i); chk({flag, rxen}, 1); wb(4'h0, 0, 0); chk(rd, 6);
      wb(4'h0, 1, 32'hb); @(posedge clk_i); chk(32'(rxen), 0); hold_lo <= 1'b1;
      @(negedge clk_i); chk(32'(wake), 1);
      @(posedge clk_i); hold_lo <= 1'b0;
      repeat (3) @(posedge clk_i); wb(4'h0, 0, 0); chk(rd, 32'hd);
      results();
   end
   // Watchdog
   initial
   begin
      repeat (5000) @(posedge clk_i);
      error_cnt++;
      results();
   end
endmodule
`default_nettype wire
